// File: rtl/channel_alarm_evaluator.sv
// Channel, consumption and state alarm evaluator with AHB-Lite registers
//
// Overview of operation
// - Eight independent channel alarms, one channel each, two for difference types
// - Report both entry and exit of alarms
// - Four consumption alarms accumulate flow per period
// - Consumption alarm fires once total passes threshold
// - Digital input edges report events, no state
// - Lower: below level, release above level+hysteresis
// - Upper: above level, release below level-hysteresis
// - Difference greater, release below level-hysteresis
// - Difference less, release above level+hysteresis
// - Rate: current minus previous exceeds level
// - Rate measured between consecutive datapoints only
// - Rate releases below level minus hysteresis
// - Rate alarm ignores falling values
// - Inside band, release outside widened band
// - Out of band, release inside narrowed band
// - Several types share channel, hysteresis, persistence
// - Persistence: m of last n datapoints
`timescale 1ns/1ns
module channel_alarm_evaluator import alarm_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Datapoint stream from the channels
  input wire logic dp_valid,
  output logic dp_ready,
  input wire dp_t dp_data,
  // Digital input pins
  input wire logic [NUM_DIN-1:0] din,
  // Alarm event stream
  output logic evt_valid,
  input wire logic evt_ready,
  output evt_t evt
);
  logic rst_s1, rst_ni;
  logic [31:0] acfg_q [NUM_ALARMS];
  logic [31:0] alim_q [NUM_ALARMS];
  logic [31:0] alvl_q [NUM_ALARMS];
  logic [31:0] ahys_q [NUM_ALARMS];
  logic [31:0] ccfg_q [NUM_CONS];
  logic [31:0] cthr_q [NUM_CONS];
  logic [7:0] stev_q;
  logic wr_q;
  logic [11:0] wad_q;
  logic [2:0] wreg_q;
  logic [VAL_W-1:0] cur_q [NUM_CHAN];
  logic [VAL_W-1:0] prev_q [NUM_CHAN];
  logic [NUM_CHAN-1:0] seen0_q, seen1_q;
  eval_st_t st_q;
  dp_t ev_q;
  logic [NUM_ALARMS-1:0] act_q, aen, aex;
  logic [NUM_CONS-1:0] cact_q, cen, cex;
  logic [NUM_DIN-1:0] s1_q, s2_q, s3_q, din_q;
  logic [PEND_W-1:0] pend_q;
  logic f_valid;
  dp_t f_data;

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_ni <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_ni <= rst_s1;
    end
  end

  // Register group of a byte address; upper address bits must be zero
  function automatic logic [2:0] region(input logic [31:0] a);
    if (a[31:12] != '0) region = R_NONE;
    else if (a[11:7] == ALM_BASE[11:7]) region = R_ALM;
    else if (a[11:5] == CONS_BASE[11:5]) region = R_CONS;
    else if (a[11:2] == STEV_OFS[11:2]) region = R_STEV;
    else if (a[11:2] == STATUS_OFS[11:2]) region = R_STAT;
    else region = R_NONE;
  endfunction

  // Address phase decode and read selection
  wire logic aphase = hsel & hready & htrans[1];
  wire logic [2:0] rreg = region(haddr);
  wire logic [2:0] ai = haddr[6:4];
  wire logic [1:0] aw = haddr[3:2];
  wire logic [1:0] ci = haddr[4:3];
  wire logic [31:0] status = {16'h0000, din_q, cact_q, act_q};
  wire logic [31:0] alm_rd = aw == W_CFG ? acfg_q[ai] : aw == W_LIM ? alim_q[ai] :
                             aw == W_LVL ? alvl_q[ai] : ahys_q[ai];
  wire logic [31:0] cons_rd = haddr[2] ? cthr_q[ci] : ccfg_q[ci];
  wire logic [31:0] rd_mux = rreg == R_ALM ? alm_rd : rreg == R_CONS ? cons_rd :
                             rreg == R_STEV ? {24'h00_0000, stev_q} :
                             rreg == R_STAT ? status : 32'h0000_0000;

  // Bus slave: zero wait states, always OKAY, data phase follows address
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      wr_q <= 1'b0;
      wad_q <= '0;
      wreg_q <= R_NONE;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_q <= aphase & hwrite;
      wad_q <= haddr[11:0];
      wreg_q <= rreg;
      hrdata <= (aphase & ~hwrite) ? rd_mux : hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Register writes in the data phase; reserved bits are dropped
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      for (int j = 0; j < NUM_ALARMS; j++) begin
        acfg_q[j] <= REG_RESET;
        alim_q[j] <= REG_RESET;
        alvl_q[j] <= REG_RESET;
        ahys_q[j] <= REG_RESET;
      end
      for (int j = 0; j < NUM_CONS; j++) begin
        ccfg_q[j] <= REG_RESET;
        cthr_q[j] <= REG_RESET;
      end
      stev_q <= '0;
    end else if (wr_q) begin
      case (wreg_q)
        R_ALM: begin
          case (wad_q[3:2])
            W_CFG: acfg_q[wad_q[6:4]] <= hwdata & CFG_MASK;
            W_LIM: alim_q[wad_q[6:4]] <= hwdata;
            W_LVL: alvl_q[wad_q[6:4]] <= hwdata;
            default: ahys_q[wad_q[6:4]] <= hwdata & HYS_MASK;
          endcase
        end
        R_CONS: begin
          if (wad_q[2]) cthr_q[wad_q[4:3]] <= hwdata;
          else ccfg_q[wad_q[4:3]] <= hwdata & CCFG_MASK;
        end
        R_STEV: stev_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Take a datapoint only when no event waits, so none is ever dropped
  wire logic pop = st_q == ST_IDLE && f_valid && pend_q == '0;

  // Incoming datapoints are buffered so bursts survive event back-pressure
  dp_fifo #(.W($bits(dp_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(core_clk),
    .rst_n(rst_ni),
    .in_valid(dp_valid),
    .in_ready(dp_ready),
    .in_data(dp_data),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  wire logic [3:0] ev_ch = ev_q.chan;
  wire logic [VAL_W-1:0] ev_val = ev_q.value;

  // Channel table: latest and previous datapoint of each channel
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      st_q <= ST_IDLE;
      ev_q <= '0;
      seen0_q <= '0;
      seen1_q <= '0;
    end else begin
      st_q <= pop ? ST_EVAL : ST_IDLE;
      ev_q <= pop ? f_data : ev_q;
      if (pop) begin
        seen0_q[f_data.chan] <= 1'b1;
        seen1_q[f_data.chan] <= seen0_q[f_data.chan];
      end
    end
  end

  // Value store has no reset; the seen flags guard its use
  always_ff @(posedge core_clk) begin
    if (pop) begin
      cur_q[f_data.chan] <= f_data.value;
      prev_q[f_data.chan] <= cur_q[f_data.chan];
    end
  end

  // Count of ones in the persistence window
  function automatic logic [3:0] ones(input logic [HIST_W-1:0] v);
    ones = '0;
    for (int j = 0; j < HIST_W; j++) ones = ones + 4'(v[j]);
  endfunction

  // One evaluator per channel alarm
  for (genvar i = 0; i < NUM_ALARMS; i++) begin : g_alm
    alarm_cfg_t c;
    logic [HIST_W-1:0] hist_q;
    logic [NUM_COND-1:0] tv, hv;
    assign c = alarm_cfg_t'(acfg_q[i]);
    wire logic need_b = c.cond[C_DGT] | c.cond[C_DLT];
    wire logic a_ok = seen0_q[c.ch_a] & (~need_b | seen0_q[c.ch_b]);
    wire logic hit = c.ch_a == ev_ch || (need_b && c.ch_b == ev_ch);
    wire logic upd = st_q == ST_EVAL && c.en && hit && a_ok;
    cond_eval u_ce (
      .va(cur_q[c.ch_a]),
      .vb(cur_q[c.ch_b]),
      .pa(prev_q[c.ch_a]),
      .lim(lim_t'(alim_q[i])),
      .lvl(lvl_t'(alvl_q[i])),
      .hys(ahys_q[i][VAL_W-1:0]),
      .trig(tv),
      .hold(hv)
    );
    // Rate needs two datapoints; all types share one hysteresis
    wire logic [NUM_COND-1:0] sel = c.cond & ~(seen1_q[c.ch_a] ? 7'h00 : ROC_MASK);
    wire logic trig_any = |(tv & sel);
    wire logic hold_any = |(hv & sel);
    wire logic [HIST_W-1:0] hist_n = {hist_q[HIST_W-2:0], trig_any};
    wire logic [HIST_W-1:0] wmask = HIST_W'((16'h0002 << c.pwin) - 16'h0001);
    wire logic go = ones(hist_n & wmask) > 4'(c.pmin);
    wire logic act_d = !c.en ? 1'b0 : !upd ? act_q[i] : act_q[i] ? hold_any : go;
    assign aen[i] = ~act_q[i] & act_d;
    assign aex[i] = act_q[i] & ~act_d;

    // Active flag held between datapoints; history restarts on change
    always_ff @(posedge core_clk or negedge rst_ni) begin
      if (!rst_ni) begin
        act_q[i] <= 1'b0;
        hist_q <= '0;
      end else begin
        act_q[i] <= act_d;
        hist_q <= (!c.en || (upd && (act_q[i] || go))) ? '0 : upd ? hist_n : hist_q;
      end
    end
  end

  // Consumption alarms: negative datapoints add nothing, totals saturate
  logic [31:0] cacc_q [NUM_CONS];
  logic [15:0] ccnt_q [NUM_CONS];
  for (genvar k = 0; k < NUM_CONS; k++) begin : g_cons
    cons_cfg_t cc;
    assign cc = cons_cfg_t'(ccfg_q[k]);
    wire logic hit = st_q == ST_EVAL && cc.en && cc.chan == ev_ch;
    wire logic [31:0] add = ev_val[VAL_W-1] ? 32'h0000_0000 : 32'(ev_val);
    wire logic [32:0] sum = {1'b0, cacc_q[k]} + {1'b0, add};
    wire logic [31:0] acc_n = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
    wire logic over = acc_n > cthr_q[k];
    wire logic [15:0] cnt_n = ccnt_q[k] + 16'h0001;
    wire logic fin = cnt_n >= cc.period;
    wire logic mid = cact_q[k] | over;
    assign cen[k] = hit & over & ~cact_q[k];
    assign cex[k] = (hit & fin & mid) | (~cc.en & cact_q[k]);

    // Total restarts at the end of each period
    always_ff @(posedge core_clk or negedge rst_ni) begin
      if (!rst_ni) begin
        cact_q[k] <= 1'b0;
        cacc_q[k] <= '0;
        ccnt_q[k] <= '0;
      end else begin
        cact_q[k] <= !cc.en ? 1'b0 : !hit ? cact_q[k] : !fin & mid;
        cacc_q[k] <= !cc.en || (hit && fin) ? '0 : hit ? acc_n : cacc_q[k];
        ccnt_q[k] <= !cc.en || (hit && fin) ? '0 : hit ? cnt_n : ccnt_q[k];
      end
    end
  end

  // Pin inputs: a change counts once stages two and three agree
  wire logic [NUM_DIN-1:0] dchg = ~(s2_q ^ s3_q) & (s3_q ^ din_q);
  wire logic [NUM_DIN-1:0] dcl = dchg & s3_q & stev_q[3:0];
  wire logic [NUM_DIN-1:0] dop = dchg & ~s3_q & stev_q[7:4];
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      din_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      din_q <= (din_q & ~dchg) | (s3_q & dchg);
    end
  end

  // Lowest pending event goes out first
  function automatic logic [4:0] first_one(input logic [PEND_W-1:0] v);
    first_one = '0;
    for (int j = PEND_W - 1; j >= 0; j--) if (v[j]) first_one = 5'(j);
  endfunction

  function automatic evt_t to_evt(input logic [4:0] n);
    to_evt.kind = n < 5'(P_CEN) ? EVT_CHAN : n < 5'(P_DCL) ? EVT_CONS : EVT_STATE;
    to_evt.idx = n < 5'(P_CEN) ? n[2:0] : {1'b0, n[1:0]};
    to_evt.enter = n < 5'(P_CEN) ? ~n[3] : ~n[2];
  endfunction

  wire logic [PEND_W-1:0] pset = {dop, dcl, cex, cen, aex, aen};
  wire logic load = ~evt_valid | evt_ready;
  wire logic [4:0] nxt = first_one(pend_q);
  wire logic [PEND_W-1:0] take = (load && pend_q != '0) ? PEND_W'(1) << nxt : '0;

  // Pending events: a new event wins over the bit being taken
  always_ff @(posedge core_clk or negedge rst_ni) begin
    if (!rst_ni) begin
      pend_q <= '0;
      evt_valid <= 1'b0;
      evt <= '0;
    end else begin
      pend_q <= (pend_q & ~take) | pset;
      evt_valid <= load ? pend_q != '0 : evt_valid;
      evt <= (take != '0) ? to_evt(nxt) : evt;
    end
  end

  // Checks on alarm 0 and the event path
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_ni);
  alarm_cfg_t c0;
  lim_t l0;
  assign c0 = alarm_cfg_t'(acfg_q[0]);
  assign l0 = lim_t'(alim_q[0]);
  wire logic signed [VAL_W+1:0] v0 = (VAL_W+2)'($signed(cur_q[c0.ch_a]));
  wire logic signed [VAL_W+1:0] p0 = (VAL_W+2)'($signed(prev_q[c0.ch_a]));
  wire logic signed [VAL_W+1:0] lo0 = (VAL_W+2)'($signed(l0.lo));
  wire logic signed [VAL_W+1:0] hi0 = (VAL_W+2)'($signed(l0.hi));
  wire logic signed [VAL_W+1:0] h0 = (VAL_W+2)'($signed(ahys_q[0][VAL_W-1:0]));

  sequence s_eval0;
    st_q == ST_EVAL && g_alm[0].upd;
  endsequence
  property p_enter(logic [6:0] m, logic cause);
    (s_eval0 ##0 (!act_q[0] && (c0.cond & m) == m && c0.pmin == 3'h0 && cause)) |=> act_q[0];
  endproperty
  property p_release(logic [6:0] m, logic cause);
    (s_eval0 ##0 (act_q[0] && c0.cond == m && cause)) |=> !act_q[0];
  endproperty

  a_lower_enter: assert property (p_enter(7'h01, v0 < lo0)) else $error("lower not entered");
  a_upper_enter: assert property (p_enter(7'h02, v0 > hi0)) else $error("upper not entered");
  a_lower_release: assert property (p_release(7'h03, v0 > lo0 + h0 && v0 < hi0 - h0))
    else $error("lower held");
  a_band_release: assert property (p_release(7'h40, v0 > lo0 + h0 && v0 < hi0 - h0))
    else $error("out of band held");
  a_roc_falling: assert property ((s_eval0 ##0 (!act_q[0] && c0.cond == ROC_MASK && v0 <= p0))
    |=> !act_q[0]) else $error("rate fired on fall");
  a_entry_event: assert property ($rose(act_q[0]) |-> pend_q[P_AEN]) else $error("no entry");
  a_exit_event: assert property ($fell(act_q[0]) |-> pend_q[P_AEX]) else $error("no exit");
  a_cons_at_once: assert property ((g_cons[0].hit && g_cons[0].over && !g_cons[0].fin && !cact_q[0])
    |=> cact_q[0] && pend_q[P_CEN]) else $error("consumption late");
  a_state_event: assert property ((dchg[0] && s3_q[0] && stev_q[0]) |=> pend_q[P_DCL])
    else $error("closed edge lost");
  a_pop_eval: assert property (pop |=> st_q == ST_EVAL ##1 st_q == ST_IDLE)
    else $error("evaluation step missing");
endmodule

// File: rtl/alarm_pkg.sv
// Shared types, register map and constants of the channel alarm evaluator
package alarm_pkg;
  localparam int NUM_ALARMS = 8;
  localparam int NUM_CONS = 4;
  localparam int NUM_DIN = 4;
  localparam int NUM_CHAN = 16;
  localparam int VAL_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int HIST_W = 8;
  // Condition select bit positions
  localparam int C_LOW = 0;
  localparam int C_UP = 1;
  localparam int C_DGT = 2;
  localparam int C_DLT = 3;
  localparam int C_ROC = 4;
  localparam int C_IN = 5;
  localparam int C_OUT = 6;
  localparam int NUM_COND = 7;
  localparam logic [6:0] ROC_MASK = 7'h10;
  // Byte offsets and register groups
  localparam logic [11:0] ALM_BASE = 12'h000;
  localparam logic [11:0] CONS_BASE = 12'h100;
  localparam logic [11:0] STEV_OFS = 12'h180;
  localparam logic [11:0] STATUS_OFS = 12'h184;
  localparam logic [1:0] W_CFG = 2'h0;
  localparam logic [1:0] W_LIM = 2'h1;
  localparam logic [1:0] W_LVL = 2'h2;
  localparam logic [1:0] W_HYS = 2'h3;
  localparam logic [2:0] R_NONE = 3'h0;
  localparam logic [2:0] R_ALM = 3'h1;
  localparam logic [2:0] R_CONS = 3'h2;
  localparam logic [2:0] R_STEV = 3'h3;
  localparam logic [2:0] R_STAT = 3'h4;
  // Writable bits and reset values
  localparam logic [31:0] CFG_MASK = 32'h0077_FFFF;
  localparam logic [31:0] CCFG_MASK = 32'hFFFF_001F;
  localparam logic [31:0] HYS_MASK = 32'h0000_FFFF;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  // Event pending vector layout
  localparam int P_AEN = 0;
  localparam int P_AEX = 8;
  localparam int P_CEN = 16;
  localparam int P_CEX = 20;
  localparam int P_DCL = 24;
  localparam int P_DOP = 28;
  localparam int PEND_W = 32;

  typedef enum logic [1:0] {EVT_CHAN = 2'h0, EVT_CONS = 2'h1, EVT_STATE = 2'h2} evt_kind_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_EVAL = 1'b1} eval_st_t;
  typedef struct packed {logic [3:0] chan; logic [VAL_W-1:0] value;} dp_t;
  typedef struct packed {evt_kind_t kind; logic [2:0] idx; logic enter;} evt_t;
  typedef struct packed {
    logic [8:0] rsvd; logic [2:0] pwin; logic pad; logic [2:0] pmin;
    logic [3:0] ch_b; logic [3:0] ch_a; logic [6:0] cond; logic en;
  } alarm_cfg_t;
  typedef struct packed {logic [VAL_W-1:0] hi; logic [VAL_W-1:0] lo;} lim_t;
  typedef struct packed {logic [VAL_W-1:0] roc; logic [VAL_W-1:0] diff;} lvl_t;
  typedef struct packed {logic [15:0] period; logic [10:0] rsvd; logic [3:0] chan; logic en;} cons_cfg_t;
endpackage

// File: rtl/dp_fifo.sv
// Datapoint FIFO with registered ready and valid
`timescale 1ns/1ns
module dp_fifo #(
  parameter int W = 20,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  wire logic push = in_valid & in_ready;
  wire logic pop = out_valid & out_ready;
  wire logic [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rp_q];

  // Storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= in_data;
  end

  // Pointers, fill count and the registered flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wp_q <= push ? AW'(wp_q + 1'b1) : wp_q;
      rp_q <= pop ? AW'(rp_q + 1'b1) : rp_q;
      cnt_q <= cnt_d;
      in_ready <= cnt_d != (AW+1)'(DEPTH);
      out_valid <= cnt_d != '0;
    end
  end
endmodule

// File: rtl/cond_eval.sv
// Comparison of one alarm's channel values against its levels
`timescale 1ns/1ns
module cond_eval import alarm_pkg::*; (
  // Current and previous values
  input wire logic signed [VAL_W-1:0] va,
  input wire logic signed [VAL_W-1:0] vb,
  input wire logic signed [VAL_W-1:0] pa,
  // Levels
  input wire lim_t lim,
  input wire lvl_t lvl,
  input wire logic signed [VAL_W-1:0] hys,
  // Per-type activation and hold results
  output logic [NUM_COND-1:0] trig,
  output logic [NUM_COND-1:0] hold
);
  // Two guard bits so sums and differences never wrap
  localparam int W = VAL_W + 2;
  wire logic signed [W-1:0] v = W'(va);
  wire logic signed [W-1:0] lo = W'($signed(lim.lo));
  wire logic signed [W-1:0] hi = W'($signed(lim.hi));
  wire logic signed [W-1:0] dl = W'($signed(lvl.diff));
  wire logic signed [W-1:0] rl = W'($signed(lvl.roc));
  wire logic signed [W-1:0] h = W'(hys);
  wire logic signed [W-1:0] d = W'(W'(va) - W'(vb));
  wire logic signed [W-1:0] r = W'(W'(va) - W'(pa));

  // Activation regions
  assign trig[C_LOW] = v < lo;
  assign trig[C_UP] = v > hi;
  assign trig[C_DGT] = d > dl;
  assign trig[C_DLT] = d < dl;
  assign trig[C_ROC] = r > rl && r > 0;
  assign trig[C_IN] = v >= lo && v <= hi;
  assign trig[C_OUT] = v < lo || v > hi;
  // Hold regions: an active alarm stays while any selected one is true
  assign hold[C_LOW] = v <= lo + h;
  assign hold[C_UP] = v >= hi - h;
  assign hold[C_DGT] = d >= dl - h;
  assign hold[C_DLT] = d <= dl + h;
  assign hold[C_ROC] = r >= rl - h;
  assign hold[C_IN] = v >= lo - h && v <= hi + h;
  assign hold[C_OUT] = v <= lo + h || v >= hi - h;
endmodule

// File: verification/dp_partner.sv
// Datapoint source and event sink beside the evaluator
`timescale 1ns/1ns
module dp_partner import alarm_pkg::*; (
  // Clock and sink stall
  input wire logic core_clk,
  input wire logic stall,
  // Datapoint stream
  output logic dp_valid,
  input wire logic dp_ready,
  output dp_t dp_data,
  // Event stream
  input wire logic evt_valid,
  output logic evt_ready,
  input wire evt_t evt
);
  evt_t evq[$];
  initial begin
    dp_valid = 1'b0;
    dp_data = '0;
    evt_ready = 1'b0;
  end
  // Hold until taken; scramble the released bus so stale data never looks valid
  task automatic send(input logic [3:0] c, input logic [15:0] v);
    dp_valid <= 1'b1;
    dp_data <= {c, v};
    do @(posedge core_clk); while (dp_ready !== 1'b1);
    dp_valid <= 1'b0;
    dp_data <= ~{c, v};
  endtask
  // Sink can stall to back events up into the datapoint path
  always @(posedge core_clk) begin
    evt_ready <= !stall;
    if (evt_valid === 1'b1 && evt_ready === 1'b1) begin
      evq.push_back(evt);
    end
  end
endmodule

// File: verification/channel_alarm_evaluator_tb_top.sv
// Self-checking bench for the channel alarm evaluator
`timescale 1ns/1ns
module channel_alarm_evaluator_tb_top import alarm_pkg::*; ;
  localparam logic [6:0] NO = 7'h40;
  logic core_clk, rst_n, hsel, hwrite, stall, dp_valid, dp_ready, evt_valid, evt_ready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [3:0] din;
  wire hreadyout, hresp;
  dp_t dp_data;
  evt_t evt;
  int bad_count, n_checks, cyc, n;
  channel_alarm_evaluator i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .dp_valid(dp_valid), .dp_ready(dp_ready),
    .dp_data(dp_data), .din(din), .evt_valid(evt_valid), .evt_ready(evt_ready), .evt(evt));
  dp_partner i_src (
    .core_clk(core_clk), .stall(stall), .dp_valid(dp_valid), .dp_ready(dp_ready),
    .dp_data(dp_data), .evt_valid(evt_valid), .evt_ready(evt_ready), .evt(evt));
  // Clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Hang guard, well above the fewer than two thousand cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // Single AHB-Lite transfer; waits on hready, never a fixed count
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(x, e);
  endtask
  function automatic logic [6:0] ev(input evt_kind_t k, input int i, input logic en);
    return {1'b0, k, 3'(i), en};
  endfunction
  // Enable last, then drop any stray events from the reconfiguration
  task automatic cfg(input int a, input logic [6:0] m, input logic [7:0] ch,
                     input logic [31:0] lim, input logic [31:0] lvl,
                     input logic [31:0] hys, input logic [31:0] pers);
    logic [11:0] b;
    b = 12'(a * 16);
    wr(b + 12'h004, lim);
    wr(b + 12'h008, lvl);
    wr(b + 12'h00C, hys);
    wr(b, pers | {16'h0000, ch, m, 1'b1});
    repeat (14) @(posedge core_clk);
    i_src.evq.delete();
  endtask
  task automatic expect_ev(input int w, input logic [6:0] ex);
    logic [6:0] got;
    repeat (w) @(posedge core_clk);
    got = NO;
    if (i_src.evq.size() > 0) begin
      got = {1'b0, i_src.evq.pop_front()};
    end
    chk({25'h0, got}, {25'h0, ex});
  endtask
  // Fixed wait covers the drain, evaluate and report walk with margin
  task automatic dp(input logic [3:0] c, input int v, input logic [6:0] ex);
    i_src.send(c, 16'(v));
    expect_ev(14, ex);
  endtask
  task automatic t_regs();
    rd(12'h000, REG_RESET);
    rd(STATUS_OFS, REG_RESET);
    wr(12'h07C, 32'hFFFF_FFFF);
    rd(12'h07C, HYS_MASK);
    wr(12'h07C, REG_RESET);
    rd(12'h1F0, REG_RESET);
    $display("done registers");
  endtask
  // Lower and upper in one alarm, hysteresis kept below band width
  task automatic t_limits();
    cfg(0, 7'h03, 8'h01, 32'h0050_0014, '0, 32'h0000_000A, '0);
    dp(1, 20, NO);
    dp(1, 19, ev(EVT_CHAN, 0, 1));
    dp(1, 30, NO);
    dp(1, 31, ev(EVT_CHAN, 0, 0));
    dp(1, 80, NO);
    dp(1, 81, ev(EVT_CHAN, 0, 1));
    rd(STATUS_OFS, 32'h0000_0001);
    dp(1, 70, NO);
    dp(1, 69, ev(EVT_CHAN, 0, 0));
    $display("done limits");
  endtask
  task automatic t_diff();
    cfg(4, 7'h04, 8'h65, '0, 32'h0000_0014, 32'h0000_000A, '0);
    dp(6, 0, NO);
    dp(5, 20, NO);
    dp(5, 21, ev(EVT_CHAN, 4, 1));
    dp(5, 11, NO);
    dp(5, 9, ev(EVT_CHAN, 4, 0));
    cfg(4, 7'h08, 8'h65, '0, 32'h0000_0014, 32'h0000_000A, '0);
    dp(5, 20, NO);
    dp(5, 19, ev(EVT_CHAN, 4, 1));
    dp(5, 30, NO);
    dp(5, 31, ev(EVT_CHAN, 4, 0));
    $display("done difference");
  endtask
  task automatic t_roc();
    cfg(3, ROC_MASK, 8'h04, '0, 32'h0014_0000, 32'h0000_0005, '0);
    dp(4, 100, NO);
    dp(4, 50, NO);
    dp(4, 70, NO);
    dp(4, 91, ev(EVT_CHAN, 3, 1));
    dp(4, 107, NO);
    dp(4, 121, ev(EVT_CHAN, 3, 0));
    // Alarm 0 on the same channel: a fall, then an out-of-band release
    cfg(0, ROC_MASK, 8'h04, '0, 32'h0014_0000, 32'h0000_0005, '0);
    dp(4, 60, NO);
    cfg(0, 7'h40, 8'h04, 32'h0050_0014, '0, 32'h0000_000A, '0);
    dp(4, 15, ev(EVT_CHAN, 0, 1));
    dp(4, 31, ev(EVT_CHAN, 0, 0));
    $display("done rate");
  endtask
  task automatic t_band();
    cfg(6, 7'h20, 8'h07, 32'h0050_0014, '0, 32'h0000_000A, '0);
    dp(7, 50, ev(EVT_CHAN, 6, 1));
    dp(7, 11, NO);
    dp(7, 90, NO);
    dp(7, 91, ev(EVT_CHAN, 6, 0));
    cfg(7, 7'h40, 8'h08, 32'h0050_0014, '0, 32'h0000_000A, '0);
    dp(8, 19, ev(EVT_CHAN, 7, 1));
    dp(8, 30, NO);
    dp(8, 31, ev(EVT_CHAN, 7, 0));
    dp(8, 81, ev(EVT_CHAN, 7, 1));
    dp(8, 70, NO);
    dp(8, 69, ev(EVT_CHAN, 7, 0));
    $display("done band");
  endtask
  task automatic t_misc();
    cfg(2, 7'h02, 8'h09, 32'h0050_0014, '0, '0, 32'h0032_0000);
    dp(9, 90, NO);
    dp(9, 0, NO);
    dp(9, 90, NO);
    dp(9, 90, ev(EVT_CHAN, 2, 1));
    dp(9, 0, ev(EVT_CHAN, 2, 0));
    wr(CONS_BASE + 12'h004, 32'h0000_0064);
    wr(CONS_BASE, 32'h0004_0007);
    dp(3, 60, NO);
    dp(3, 50, ev(EVT_CONS, 0, 1));
    dp(3, 0, NO);
    dp(3, 0, ev(EVT_CONS, 0, 0));
    wr(STEV_OFS, 32'h0000_0011);
    din <= 4'h1;
    expect_ev(40, ev(EVT_STATE, 0, 1));
    din <= 4'h0;
    expect_ev(40, ev(EVT_STATE, 0, 0));
    $display("done persistence consumption state");
  endtask
  // Stalled sink blocks draining, so the FIFO must fill and refuse
  task automatic t_fill();
    cfg(0, 7'h02, 8'h01, 32'h0050_0014, '0, 32'h0000_000A, '0);
    stall <= 1'b1;
    i_src.send(4'h1, 16'h0051);
    repeat (10) @(posedge core_clk);
    // Exit queues behind the stalled entry, so draining stops
    i_src.send(4'h1, 16'h0032);
    repeat (10) @(posedge core_clk);
    n = 0;
    while (dp_ready === 1'b1 && n < 40) begin
      i_src.send(4'h1, 16'h0051);
      n++;
      @(posedge core_clk);
    end
    chk(32'(n), 32'(FIFO_DEPTH));
    stall <= 1'b0;
    expect_ev(300, ev(EVT_CHAN, 0, 1));
    expect_ev(1, ev(EVT_CHAN, 0, 0));
    chk({31'h0, dp_ready}, 32'h0000_0001);
    $display("done fill");
  endtask
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = '0;
    din = 4'h0;
    stall = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_regs();
    t_limits();
    t_diff();
    t_roc();
    t_band();
    t_misc();
    t_fill();
    report_and_stop();
  end
endmodule
